// [debug_break_watch_unit.sv]
// debug compare unit: breakpoints, watchpoints, trigger data, stop vector, scratch
`timescale 1ns/1ps
`default_nettype none
`include "dbg_watch_defines.svh"
module debug_break_watch_unit
  import dbg_watch_pkg::*;
#(
  parameter int NSLOT = 4,
  parameter int NTHR = 8,
  parameter int NSCRATCH = 8
) (
  input wire logic clk_sys,
  input wire logic nrst,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // pipeline observation
  input wire logic pc_valid,
  input wire logic [$clog2(NTHR)-1:0] pc_thread,
  input wire logic [31:0] pc_value,
  input wire logic mem_valid,
  input wire logic mem_is_load,
  input wire logic [$clog2(NTHR)-1:0] mem_thread,
  input wire logic [31:0] mem_addr,
  input wire logic res_valid,
  input wire logic [$clog2(NTHR)-1:0] res_thread,
  input wire logic [31:0] res_id,
  input wire logic in_debug_mode,
  // pipeline control
  output logic debug_irq_req,
  output logic [2:0] debug_cause_code,
  output logic [NTHR-1:0] thread_stop,
  // tile configuration view of the scratch words
  input wire logic cfg_scratch_we,
  input wire logic [$clog2(NSCRATCH)-1:0] cfg_scratch_idx,
  input wire logic [31:0] cfg_scratch_wdata,
  output logic [31:0] cfg_scratch_rdata,
  // software interrupt
  output logic irq
);

  localparam int SW = $clog2(NSLOT);
  localparam int SCW = $clog2(NSCRATCH);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [31:0] trig_data;
    logic [NTHR-1:0] stop_vec;
    logic [NSCRATCH-1:0][31:0] scratch;
    logic [NSLOT-1:0][31:0] ib_addr;
    logic [NSLOT-1:0][31:0] ib_ctrl;
    logic [NSLOT-1:0][31:0] dw_first;
    logic [NSLOT-1:0][31:0] dw_second;
    logic [NSLOT-1:0][31:0] dw_ctrl;
    logic [NSLOT-1:0][31:0] rw_mask;
    logic [NSLOT-1:0][31:0] rw_value;
    logic [NSLOT-1:0][31:0] rw_ctrl;
    logic [2:0] cause;
    logic dbg_req;
    logic [NTHR-1:0] stop_out;
    logic [31:0] cfg_rdata;
  } st_t;

  st_t st_q;
  st_t st_d;

  logic ib_hit;
  logic dw_hit;
  logic rw_hit;
  logic [2:0] ev_take;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic irq_clr_we;
  logic irq_mask_we;
  logic [7:0] idx;
  logic bus_req;
  logic bus_wr;
  logic addr_ok;
  hit_src_t src;

  // ****************************************
  // helpers
  // ****************************************
  // byte-lane merge of a write
  function automatic word_t merge(input word_t old, input word_t nw, input logic [3:0] sel);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        merge[8*b +: 8] = nw[8*b +: 8];
      end
    end
  endfunction : merge

  // index lies in a group of four slots at base
  function automatic logic in_group4(input logic [7:0] i, input logic [7:0] base);
    in_group4 = (i[7:2] == base[7:2]);
  endfunction : in_group4

  // index lies in the group of eight scratch words
  function automatic logic in_group8(input logic [7:0] i, input logic [7:0] base);
    in_group8 = (i[7:3] == base[7:3]);
  endfunction : in_group8

  // ****************************************
  // comparators
  // ****************************************
  watch_match #(
    .NSLOT(NSLOT),
    .NTHR(NTHR)
  ) u_match (
    .ib_addr(st_q.ib_addr),
    .ib_ctrl(st_q.ib_ctrl),
    .dw_first(st_q.dw_first),
    .dw_second(st_q.dw_second),
    .dw_ctrl(st_q.dw_ctrl),
    .rw_mask(st_q.rw_mask),
    .rw_value(st_q.rw_value),
    .rw_ctrl(st_q.rw_ctrl),
    .pc_valid(pc_valid),
    .pc_thread(pc_thread),
    .pc_value(pc_value),
    .mem_valid(mem_valid),
    .mem_is_load(mem_is_load),
    .mem_thread(mem_thread),
    .mem_addr(mem_addr),
    .res_valid(res_valid),
    .res_thread(res_thread),
    .res_id(res_id),
    .ib_hit(ib_hit),
    .dw_hit(dw_hit),
    .rw_hit(rw_hit)
  );

  // ****************************************
  // bus decode
  // ****************************************
  assign idx = wb_adr_i[9:2];
  assign addr_ok = (wb_adr_i[31:10] == 22'h000000);
  assign bus_req = wb_cyc_i && wb_stb_i && !st_q.ack;
  assign bus_wr = bus_req && wb_we_i && addr_ok;

  // interrupt status and mask writes
  assign irq_clr_we = bus_wr && (idx == `DBW_IDX_IRQ_STATUS);
  assign irq_mask_we = bus_wr && (idx == `DBW_IDX_IRQ_MASK);

  // ****************************************
  // event priority: breakpoint, data, resource
  // ****************************************
  always_comb begin
    src = SRC_NONE;
    if (!in_debug_mode && !st_q.dbg_req) begin
      if (ib_hit) begin
        src = SRC_IBREAK;
      end else if (dw_hit) begin
        src = SRC_DWATCH;
      end else if (rw_hit) begin
        src = SRC_RWATCH;
      end
    end
  end

  assign ev_take = {src == SRC_RWATCH, src == SRC_DWATCH, src == SRC_IBREAK};

  event_irq #(
    .NEV(3)
  ) u_irq (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ev_set(ev_take),
    .clr_we(irq_clr_we),
    .clr_bits(wb_dat_i[2:0]),
    .mask_we(irq_mask_we),
    .mask_bits(wb_dat_i[2:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [SW-1:0] slot;
    logic [SCW-1:0] sidx;
    st_d = st_q;
    slot = idx[SW-1:0];
    sidx = idx[SCW-1:0];

    // answer every strobe once, unmapped reads return zero
    st_d.ack = bus_req;
    st_d.rdata = 32'h00000000;

    // scratch view of the configuration port, read one cycle later
    if (cfg_scratch_we) begin
      st_d.scratch[cfg_scratch_idx] = cfg_scratch_wdata;
    end
    st_d.cfg_rdata = st_q.scratch[cfg_scratch_idx];

    // register writes
    if (bus_wr) begin
      if (idx == `DBW_IDX_TRIG_DATA) begin
        st_d.trig_data = merge(st_q.trig_data, wb_dat_i, wb_sel_i);
      end else if (idx == `DBW_IDX_STOP_VEC) begin
        st_d.stop_vec = NTHR'(merge({{(32-NTHR){1'b0}}, st_q.stop_vec}, wb_dat_i, wb_sel_i));
      end else if (in_group8(idx, `DBW_IDX_SCRATCH)) begin
        st_d.scratch[sidx] = merge(st_q.scratch[sidx], wb_dat_i, wb_sel_i);
      end else if (in_group4(idx, `DBW_IDX_IB_ADDR)) begin
        st_d.ib_addr[slot] = merge(st_q.ib_addr[slot], wb_dat_i, wb_sel_i);
      end else if (in_group4(idx, `DBW_IDX_IB_CTRL)) begin
        st_d.ib_ctrl[slot] = merge(st_q.ib_ctrl[slot], wb_dat_i, wb_sel_i)
                             & `DBW_IB_CTRL_BITS;
      end else if (in_group4(idx, `DBW_IDX_DW_FIRST)) begin
        st_d.dw_first[slot] = merge(st_q.dw_first[slot], wb_dat_i, wb_sel_i);
      end else if (in_group4(idx, `DBW_IDX_DW_SECOND)) begin
        st_d.dw_second[slot] = merge(st_q.dw_second[slot], wb_dat_i, wb_sel_i);
      end else if (in_group4(idx, `DBW_IDX_DW_CTRL)) begin
        st_d.dw_ctrl[slot] = merge(st_q.dw_ctrl[slot], wb_dat_i, wb_sel_i)
                             & `DBW_DW_CTRL_BITS;
      end else if (in_group4(idx, `DBW_IDX_RW_MASK)) begin
        st_d.rw_mask[slot] = merge(st_q.rw_mask[slot], wb_dat_i, wb_sel_i);
      end else if (in_group4(idx, `DBW_IDX_RW_VALUE)) begin
        st_d.rw_value[slot] = merge(st_q.rw_value[slot], wb_dat_i, wb_sel_i);
      end else if (in_group4(idx, `DBW_IDX_RW_CTRL)) begin
        st_d.rw_ctrl[slot] = merge(st_q.rw_ctrl[slot], wb_dat_i, wb_sel_i)
                             & `DBW_RW_CTRL_BITS;
      end
    end

    // register reads
    if (bus_req && !wb_we_i && addr_ok) begin
      if (idx == `DBW_IDX_CAUSE) begin
        st_d.rdata = {29'h00000000, st_q.cause};
      end else if (idx == `DBW_IDX_TRIG_DATA) begin
        st_d.rdata = st_q.trig_data;
      end else if (idx == `DBW_IDX_STOP_VEC) begin
        st_d.rdata = {{(32-NTHR){1'b0}}, st_q.stop_vec};
      end else if (in_group8(idx, `DBW_IDX_SCRATCH)) begin
        st_d.rdata = st_q.scratch[sidx];
      end else if (in_group4(idx, `DBW_IDX_IB_ADDR)) begin
        st_d.rdata = st_q.ib_addr[slot];
      end else if (in_group4(idx, `DBW_IDX_IB_CTRL)) begin
        st_d.rdata = st_q.ib_ctrl[slot];
      end else if (in_group4(idx, `DBW_IDX_DW_FIRST)) begin
        st_d.rdata = st_q.dw_first[slot];
      end else if (in_group4(idx, `DBW_IDX_DW_SECOND)) begin
        st_d.rdata = st_q.dw_second[slot];
      end else if (in_group4(idx, `DBW_IDX_DW_CTRL)) begin
        st_d.rdata = st_q.dw_ctrl[slot];
      end else if (in_group4(idx, `DBW_IDX_RW_MASK)) begin
        st_d.rdata = st_q.rw_mask[slot];
      end else if (in_group4(idx, `DBW_IDX_RW_VALUE)) begin
        st_d.rdata = st_q.rw_value[slot];
      end else if (in_group4(idx, `DBW_IDX_RW_CTRL)) begin
        st_d.rdata = st_q.rw_ctrl[slot];
      end else if (idx == `DBW_IDX_IRQ_STATUS) begin
        st_d.rdata = {29'h00000000, irq_status};
      end else if (idx == `DBW_IDX_IRQ_MASK) begin
        st_d.rdata = {29'h00000000, irq_mask};
      end
    end

    // trigger capture: hardware wins over a same-cycle software write
    st_d.dbg_req = 1'b0;
    case (src)
      SRC_IBREAK: begin
        st_d.dbg_req = 1'b1;
        st_d.cause = `DBW_CAUSE_IBREAK;
      end
      SRC_DWATCH: begin
        st_d.dbg_req = 1'b1;
        st_d.cause = `DBW_CAUSE_DWATCH;
        st_d.trig_data = mem_addr;
      end
      SRC_RWATCH: begin
        st_d.dbg_req = 1'b1;
        st_d.cause = `DBW_CAUSE_RWATCH;
        st_d.trig_data = res_id;
      end
      default: begin
        st_d.dbg_req = 1'b0;
      end
    endcase

    // marked threads are held outside debug mode, again from one cycle after return
    st_d.stop_out = in_debug_mode ? '0 : st_q.stop_vec;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  assign wb_ack_o = st_q.ack;
  assign wb_dat_o = st_q.rdata;
  assign debug_irq_req = st_q.dbg_req;
  assign debug_cause_code = st_q.cause;
  assign thread_stop = st_q.stop_out;
  assign cfg_scratch_rdata = st_q.cfg_rdata;

endmodule : debug_break_watch_unit
`default_nettype wire

// [dbg_watch_defines.svh]
// register indices, field positions, reset values and cause codes of the debug compare unit
// What this block does
// - data watch hit loads trigger data register with the access's effective address
// - resource watch hit loads trigger data register with the resource identifier
// - eight-bit stop vector holds marked threads whenever not in debug mode; the registered output follows debug mode one cycle late
// - eight scratch words shared with the tile configuration port, one storage
// - enabled instruction breakpoint matching an enabled thread's pc raises debug interrupt
// - four instruction breakpoints, each with own address and control slot
// - breakpoint control bits 23:16 enable threads, reset zero
// - breakpoint control bit 1: zero breaks on equal, one on different
// - breakpoint control bit 0 is master enable, reset zero
// - four data watchpoints with first and second address registers
// - data watch control bit 1: zero needs A and B, one needs either
// - data watch control bit 2 lets loads trigger; clear, loads never do
// - data watch control carries thread enables and master enable, reset zero
// - four resource watchpoints with mask and value registers
// - resource watch control bit 1: zero fires on A, one on B
// - resource watch control carries thread enables and master enable, reset zero
// - cause code recorded: breakpoint 3, data watch 4, resource watch 5
`ifndef DBG_WATCH_DEFINES_SVH
`define DBG_WATCH_DEFINES_SVH

// ****************************************
// register indices, byte address is four times the index
// ****************************************
`define DBW_IDX_CAUSE 8'h15
`define DBW_IDX_TRIG_DATA 8'h16
`define DBW_IDX_STOP_VEC 8'h18
`define DBW_IDX_SCRATCH 8'h20
`define DBW_IDX_IB_ADDR 8'h30
`define DBW_IDX_IB_CTRL 8'h40
`define DBW_IDX_DW_FIRST 8'h50
`define DBW_IDX_DW_SECOND 8'h60
`define DBW_IDX_DW_CTRL 8'h70
`define DBW_IDX_RW_MASK 8'h80
`define DBW_IDX_RW_VALUE 8'h90
`define DBW_IDX_RW_CTRL 8'h9c
`define DBW_IDX_IRQ_STATUS 8'ha0
`define DBW_IDX_IRQ_MASK 8'ha1

// ****************************************
// control fields
// ****************************************
`define DBW_CTL_EN 0
`define DBW_CTL_MODE 1
`define DBW_CTL_LOAD 2
`define DBW_CTL_THR_LO 16
`define DBW_IB_CTRL_BITS 32'h00ff0003
`define DBW_DW_CTRL_BITS 32'h00ff0007
`define DBW_RW_CTRL_BITS 32'h00ff0003
`define DBW_STOP_BITS 32'h000000ff

// ****************************************
// reset values and cause codes
// ****************************************
`define DBW_CTRL_RESET 32'h00000000
`define DBW_CAUSE_IBREAK 3'h3
`define DBW_CAUSE_DWATCH 3'h4
`define DBW_CAUSE_RWATCH 3'h5

`endif

// [dbg_watch_pkg.sv]
// types shared by the debug compare unit
package dbg_watch_pkg;
  typedef logic [31:0] word_t;
  typedef enum logic [1:0] {SRC_NONE, SRC_IBREAK, SRC_DWATCH, SRC_RWATCH} hit_src_t;
endpackage : dbg_watch_pkg

// [watch_match.sv]
// compare logic for breakpoints, data watchpoints and resource watchpoints
`timescale 1ns/1ps
`default_nettype none
`include "dbg_watch_defines.svh"
module watch_match
  import dbg_watch_pkg::*;
#(
  parameter int NSLOT = 4,
  parameter int NTHR = 8
) (
  input wire logic [NSLOT-1:0][31:0] ib_addr,
  input wire logic [NSLOT-1:0][31:0] ib_ctrl,
  input wire logic [NSLOT-1:0][31:0] dw_first,
  input wire logic [NSLOT-1:0][31:0] dw_second,
  input wire logic [NSLOT-1:0][31:0] dw_ctrl,
  input wire logic [NSLOT-1:0][31:0] rw_mask,
  input wire logic [NSLOT-1:0][31:0] rw_value,
  input wire logic [NSLOT-1:0][31:0] rw_ctrl,
  input wire logic pc_valid,
  input wire logic [$clog2(NTHR)-1:0] pc_thread,
  input wire logic [31:0] pc_value,
  input wire logic mem_valid,
  input wire logic mem_is_load,
  input wire logic [$clog2(NTHR)-1:0] mem_thread,
  input wire logic [31:0] mem_addr,
  input wire logic res_valid,
  input wire logic [$clog2(NTHR)-1:0] res_thread,
  input wire logic [31:0] res_id,
  output logic ib_hit,
  output logic dw_hit,
  output logic rw_hit
);

  // master enable and per-thread enable together
  function automatic logic armed(input word_t ctrl, input logic [$clog2(NTHR)-1:0] thr);
    armed = ctrl[`DBW_CTL_EN] & ctrl[`DBW_CTL_THR_LO + int'(thr)];
  endfunction : armed

  // ****************************************
  // per-slot comparisons, any slot hits
  // ****************************************
  always_comb begin
    logic cond_a;
    logic cond_b;
    logic pc_eq;
    ib_hit = 1'b0;
    dw_hit = 1'b0;
    rw_hit = 1'b0;
    cond_a = 1'b0;
    cond_b = 1'b0;
    pc_eq = 1'b0;
    for (int s = 0; s < NSLOT; s++) begin
      // instruction breakpoint
      pc_eq = (pc_value == ib_addr[s]);
      if (pc_valid && armed(ib_ctrl[s], pc_thread) &&
          (ib_ctrl[s][`DBW_CTL_MODE] ? !pc_eq : pc_eq)) begin
        ib_hit = 1'b1;
      end
      // data watchpoint
      cond_a = (mem_addr >= dw_first[s]);
      cond_b = (mem_addr <= dw_second[s]);
      if (mem_valid && armed(dw_ctrl[s], mem_thread) &&
          (!mem_is_load || dw_ctrl[s][`DBW_CTL_LOAD]) &&
          (dw_ctrl[s][`DBW_CTL_MODE] ? (cond_a | cond_b) : (cond_a & cond_b))) begin
        dw_hit = 1'b1;
      end
      // resource watchpoint
      cond_a = ((res_id & rw_mask[s]) == rw_value[s]);
      cond_b = !cond_a;
      if (res_valid && armed(rw_ctrl[s], res_thread) &&
          (rw_ctrl[s][`DBW_CTL_MODE] ? cond_b : cond_a)) begin
        rw_hit = 1'b1;
      end
    end
  end

endmodule : watch_match
`default_nettype wire

// [event_irq.sv]
// sticky event status, mask and level interrupt
`timescale 1ns/1ps
`default_nettype none
module event_irq #(
  parameter int NEV = 3
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [NEV-1:0] ev_set,
  input wire logic clr_we,
  input wire logic [NEV-1:0] clr_bits,
  input wire logic mask_we,
  input wire logic [NEV-1:0] mask_bits,
  output logic [NEV-1:0] status,
  output logic [NEV-1:0] mask,
  output logic irq
);

  typedef struct packed {
    logic [NEV-1:0] status;
    logic [NEV-1:0] mask;
    logic irq;
  } irq_st_t;

  irq_st_t st_q;
  irq_st_t st_d;

  // write one to clear, a new event wins over the clear
  always_comb begin
    st_d = st_q;
    st_d.status = (st_q.status & ~(clr_we ? clr_bits : '0)) | ev_set;
    if (mask_we) begin
      st_d.mask = mask_bits;
    end
    st_d.irq = |(st_d.status & st_d.mask);
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign status = st_q.status;
  assign mask = st_q.mask;
  assign irq = st_q.irq;

endmodule : event_irq
`default_nettype wire

// [dbw_properties.sv]
// concurrent checks on the ports of the debug compare unit
`timescale 1ns/1ps
`default_nettype none
module dbw_checker #(
  parameter int NTHR = 8
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic pc_valid,
  input wire logic mem_valid,
  input wire logic res_valid,
  input wire logic in_debug_mode,
  input wire logic debug_irq_req,
  input wire logic [2:0] debug_cause_code,
  input wire logic [NTHR-1:0] thread_stop
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ****************************************
  // register bus and debug request checks
  // ****************************************
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_req_pulse; debug_irq_req |=> !debug_irq_req; endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("debug request too long");
  property p_no_hit_dbg; in_debug_mode |=> !debug_irq_req; endproperty
  a_no_hit_dbg: assert property (p_no_hit_dbg) else $error("hit taken in debug mode");
  property p_stop_dbg; in_debug_mode |=> thread_stop == '0; endproperty
  a_stop_dbg: assert property (p_stop_dbg) else $error("threads stopped in debug mode");
  property p_ib_cause; debug_irq_req && debug_cause_code == 3'h3 |-> $past(pc_valid); endproperty
  a_ib_cause: assert property (p_ib_cause) else $error("breakpoint without pc");
  property p_dw_cause; debug_irq_req && debug_cause_code == 3'h4 |-> $past(mem_valid); endproperty
  a_dw_cause: assert property (p_dw_cause) else $error("data watch without access");
  property p_rw_cause; debug_irq_req && debug_cause_code == 3'h5 |-> $past(res_valid); endproperty
  a_rw_cause: assert property (p_rw_cause) else $error("resource watch without access");
  property p_cause_code; debug_irq_req |-> debug_cause_code inside {3'h3, 3'h4, 3'h5}; endproperty
  a_cause_code: assert property (p_cause_code) else $error("bad cause code");
  property p_cause_hold; !debug_irq_req |-> $stable(debug_cause_code); endproperty
  a_cause_hold: assert property (p_cause_hold) else $error("cause changed without hit");
  // main scenarios reached
  c_ib: cover property (debug_irq_req && debug_cause_code == 3'h3);
  c_dw: cover property (debug_irq_req && debug_cause_code == 3'h4);
  c_rw: cover property (debug_irq_req && debug_cause_code == 3'h5);
endmodule : dbw_checker
bind debug_break_watch_unit dbw_checker #(.NTHR(NTHR)) i_dbw_checker (
  .clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pc_valid(pc_valid), .mem_valid(mem_valid),
  .res_valid(res_valid), .in_debug_mode(in_debug_mode), .debug_irq_req(debug_irq_req),
  .debug_cause_code(debug_cause_code), .thread_stop(thread_stop)
);
`default_nettype wire

// [core_debug_model.sv]
// behavioural core: enters debug mode on a request, returns after a dwell
`timescale 1ns/1ps
`default_nettype none
module core_debug_model #(
  parameter int DWELL = 3
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic debug_irq_req,
  input wire logic stay,
  output logic in_debug_mode
);
  typedef struct packed {logic dbg; logic [7:0] cnt;} core_st_t;
  core_st_t st_q;
  core_st_t st_d;
  // enter on request, held by the debugger, else leave once the dwell runs out
  always_comb begin
    st_d = st_q;
    if (debug_irq_req) begin
      st_d.dbg = 1'b1;
      st_d.cnt = 8'(DWELL);
    end else if (stay) begin
      st_d.dbg = 1'b1;
    end else if (st_q.cnt != 8'h0) begin
      st_d.cnt = st_q.cnt - 8'h1;
    end else begin
      st_d.dbg = 1'b0;
    end
  end
  // state register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign in_debug_mode = st_q.dbg;
endmodule : core_debug_model
`default_nettype wire

// [debug_break_watch_unit_tb.sv]
// self-checking bench for the debug compare unit
`timescale 1ns/1ps
`default_nettype none
module debug_break_watch_unit_tb
  import dbg_watch_pkg::*;
;
  logic clk_sys, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, stay, irq;
  logic pc_valid, mem_valid, mem_is_load, res_valid, in_debug_mode, debug_irq_req;
  logic cfg_scratch_we;
  logic [3:0] wb_sel_i;
  logic [2:0] pc_thread, mem_thread, res_thread, cfg_scratch_idx, debug_cause_code;
  logic [7:0] thread_stop;
  word_t wb_adr_i, wb_dat_i, wb_dat_o, pc_value, mem_addr, res_id, rd;
  word_t cfg_scratch_wdata, cfg_scratch_rdata;
  int fail_count, cmp_count, cycles;
  // ordinary register cases: word index, write data, read back
  word_t rows [10][3] = '{'{32'h40, 32'hffffffff, 32'h00ff0003},
    '{32'h70, 32'hffffffff, 32'h00ff0007}, '{32'h9f, 32'hffffffff, 32'h00ff0003},
    '{32'h18, 32'hffffffff, 32'h000000ff}, '{32'h27, 32'h12345678, 32'h12345678},
    '{32'h33, 32'hdeadbeef, 32'hdeadbeef}, '{32'h53, 32'h0000a5a5, 32'h0000a5a5},
    '{32'h93, 32'h5a5a0000, 32'h5a5a0000}, '{32'h15, 32'hffffffff, 32'h00000000},
    '{32'h400, 32'hffffffff, 32'h00000000}};
  debug_break_watch_unit i_debug_break_watch_unit (.clk_sys, .nrst, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pc_valid, .pc_thread,
    .pc_value, .mem_valid, .mem_is_load, .mem_thread, .mem_addr, .res_valid, .res_thread,
    .res_id, .in_debug_mode, .debug_irq_req, .debug_cause_code, .thread_stop,
    .cfg_scratch_we, .cfg_scratch_idx, .cfg_scratch_wdata, .cfg_scratch_rdata, .irq);
  core_debug_model i_core_debug_model (.clk_sys, .nrst, .debug_irq_req, .stay, .in_debug_mode);
  // ****************************************
  // clock, timeout and shared tasks
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // hang guard
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic check(input word_t seen, input word_t exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  // one classic wishbone cycle on a word index
  task automatic wb(input logic we, input word_t a, input word_t d);
    int n;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {a[29:0], 2'h0};
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    check(word_t'(wb_ack_o), 32'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic wr(input word_t a, input word_t d);
    wb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input word_t a, input word_t exp);
    wb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdc
  // one pipeline sample on pc, memory and resource lanes picked by k
  task automatic hit(input logic [2:0] k, input logic [2:0] t, input word_t v, input logic ld,
                     input logic [2:0] cause);
    @(posedge clk_sys);
    pc_valid <= k[0];
    mem_valid <= k[1];
    res_valid <= k[2];
    {pc_thread, mem_thread, res_thread} <= {t, t, t};
    {pc_value, mem_addr, res_id} <= {v, v, v};
    mem_is_load <= ld;
    @(posedge clk_sys);
    {pc_valid, mem_valid, res_valid} <= 3'h0;
    #1;
    check(word_t'(debug_irq_req), word_t'(cause != 3'h0));
    if (cause != 3'h0) check(word_t'(debug_cause_code), word_t'(cause));
    repeat (6) @(posedge clk_sys);
  endtask : hit
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {nrst, wb_cyc_i, wb_stb_i, wb_we_i, stay, pc_valid, mem_valid, res_valid} = '0;
    {mem_is_load, cfg_scratch_we, pc_thread, mem_thread, res_thread, cfg_scratch_idx} = '0;
    {wb_adr_i, wb_dat_i, pc_value, mem_addr, res_id, cfg_scratch_wdata} = '0;
    wb_sel_i = 4'hf;
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    rdc(32'h40, 32'h0);
    rdc(32'h70, 32'h0);
    rdc(32'h9c, 32'h0);
    foreach (rows[i]) begin
      wr(rows[i][0], rows[i][1]);
      rdc(rows[i][0], rows[i][2]);
    end
    wr(32'h40, 32'h0);
    wr(32'h70, 32'h0);
    wr(32'h9f, 32'h0);
    // instruction breakpoint slot 1, thread 2
    wr(32'h31, 32'h1000);
    wr(32'h41, 32'h00040000);
    hit(3'b001, 3'h2, 32'h1000, 1'b0, 3'h0);
    wr(32'h41, 32'h00040001);
    hit(3'b001, 3'h3, 32'h1000, 1'b0, 3'h0);
    hit(3'b001, 3'h2, 32'h1000, 1'b0, 3'h3);
    wr(32'h41, 32'h00040003);
    hit(3'b001, 3'h2, 32'h1000, 1'b0, 3'h0);
    hit(3'b001, 3'h2, 32'h1004, 1'b0, 3'h3);
    // data watch slot 2, range 0x100..0x1ff, thread 0
    wr(32'h52, 32'h100);
    wr(32'h62, 32'h1ff);
    wr(32'h72, 32'h00010001);
    hit(3'b010, 3'h0, 32'h100, 1'b0, 3'h4);
    rdc(32'h16, 32'h100);
    hit(3'b010, 3'h0, 32'h180, 1'b1, 3'h0);
    hit(3'b010, 3'h1, 32'h180, 1'b0, 3'h0);
    hit(3'b010, 3'h0, 32'h200, 1'b0, 3'h0);
    wr(32'h72, 32'h00010007);
    hit(3'b010, 3'h0, 32'h200, 1'b1, 3'h4);
    rdc(32'h16, 32'h200);
    // resource watch slot 3, thread 7
    wr(32'h83, 32'h0000ff00);
    wr(32'h93, 32'h00001200);
    wr(32'h9f, 32'h00800001);
    hit(3'b100, 3'h7, 32'h00ab12cd, 1'b0, 3'h5);
    rdc(32'h16, 32'h00ab12cd);
    hit(3'b100, 3'h6, 32'h00ab12cd, 1'b0, 3'h0);
    wr(32'h9f, 32'h00800003);
    hit(3'b100, 3'h7, 32'h00ab12cd, 1'b0, 3'h0);
    hit(3'b100, 3'h7, 32'h00003400, 1'b0, 3'h5);
    // all three fire together: breakpoint wins, data left alone
    wr(32'h41, 32'h00ff0003);
    wr(32'h72, 32'h00ff0007);
    hit(3'b111, 3'h7, 32'h150, 1'b0, 3'h3);
    rdc(32'h16, 32'h3400);
    // sticky status, mask and level interrupt
    rdc(32'ha0, 32'h7);
    check(word_t'(irq), 32'h0);
    wr(32'ha1, 32'h2);
    repeat (2) @(posedge clk_sys);
    #1 check(word_t'(irq), 32'h1);
    wr(32'ha0, 32'h2);
    repeat (2) @(posedge clk_sys);
    #1 check(word_t'(irq), 32'h0);
    rdc(32'ha0, 32'h5);
    // stop vector outside and inside debug mode
    wr(32'h18, 32'h5);
    repeat (2) @(posedge clk_sys);
    #1 check(word_t'(thread_stop), 32'h5);
    @(posedge clk_sys);
    stay <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 check(word_t'(thread_stop), 32'h0);
    hit(3'b001, 3'h7, 32'h0, 1'b0, 3'h0);
    @(posedge clk_sys);
    stay <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 check(word_t'(thread_stop), 32'h5);
    // scratch words seen from both ports
    wr(32'h23, 32'hcafe0023);
    @(posedge clk_sys);
    cfg_scratch_idx <= 3'h3;
    @(posedge clk_sys);
    #1 check(cfg_scratch_rdata, 32'hcafe0023);
    @(posedge clk_sys);
    {cfg_scratch_we, cfg_scratch_idx, cfg_scratch_wdata} <= {1'b1, 3'h5, 32'hbeef0005};
    @(posedge clk_sys);
    cfg_scratch_we <= 1'b0;
    rdc(32'h25, 32'hbeef0005);
    tally_and_finish();
  end
endmodule : debug_break_watch_unit_tb
`default_nettype wire
